// ==== shared/smdg_defines.svh ====
// Operation
// - idle: processor clock stops; serial, converter, memory, timers, interrupts run.
// - power-down: main oscillator stops, register contents kept, all else off.
// - power-down exits only on external interrupt or hardware reset.
// - power-save: asynchronous timer keeps running while the rest sleeps.
// - noise reduction: only asynchronous timer, converter and main oscillator clocks run.
// - standby: main oscillator runs while all other logic sleeps.
// - extended standby: main oscillator and asynchronous timer both run.
`ifndef SMDG_DEFINES_SVH
`define SMDG_DEFINES_SVH

// ----------------------------------------
// mode encodings
// ----------------------------------------
`define SMDG_MODE_IDLE      3'h0
`define SMDG_MODE_NOISE     3'h1
`define SMDG_MODE_PDOWN     3'h2
`define SMDG_MODE_PSAVE     3'h3
`define SMDG_MODE_STANDBY   3'h6
`define SMDG_MODE_XSTANDBY  3'h7

// ----------------------------------------
// clock enable vector bit positions
// ----------------------------------------
`define SMDG_EN_OSC   0
`define SMDG_EN_CPU   1
`define SMDG_EN_IO    2
`define SMDG_EN_ADC   3
`define SMDG_EN_ASY   4
`define SMDG_EN_W     5
`define SMDG_EN_ALL   5'h1f

`endif

// ==== shared/smdg_pkg.sv ====
`default_nettype none
package smdg_pkg;
  typedef enum logic [2:0] {
    SMDG_ACTIVE = 3'h1,
    SMDG_SLEEP  = 3'h2,
    SMDG_WAKE   = 3'h4
  } smdg_state_type;

  typedef struct packed {
    logic ext_irq;
    logic int_irq;
  } smdg_wake_type;

  typedef struct packed {
    logic asy;
    logic adc;
    logic io;
    logic cpu;
    logic osc;
  } smdg_clk_en_type;
endpackage
`default_nettype wire

// ==== src/smdg_sync.sv ====
`default_nettype none
module smdg_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);
  logic [1:0] st;
  logic [1:0] next_st;

  always_comb begin
    next_st = {st[0], d};
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= 2'h0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st[1];
endmodule // smdg_sync
`default_nettype wire

// ==== src/smdg_ctrl.sv ====
`include "smdg_defines.svh"
`default_nettype none
module smdg_ctrl (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic [2:0]              mode_sel,
  input  wire logic                    sleep_req,
  input  wire logic                    ext_irq_pin,
  input  wire logic                    int_irq,
  output var smdg_pkg::smdg_clk_en_type clk_en,
  output logic                         sleeping,
  output logic                         mode_bad
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    smdg_pkg::smdg_state_type  fsm;
    logic [2:0]                mode;
    smdg_pkg::smdg_clk_en_type en;
    logic                      bad;
  } smdg_regs_type;

  smdg_regs_type r;
  smdg_regs_type next_r;
  smdg_pkg::smdg_wake_type wake;
  logic ext_sync;
  logic mode_ok;
  logic wake_ok;
  smdg_pkg::smdg_clk_en_type sleep_en;

  // pin is asynchronous, so two flops first
  smdg_sync u_ext_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (ext_irq_pin),
    .q     (ext_sync)
  );

  assign wake.ext_irq = ext_sync;
  assign wake.int_irq = int_irq;

  // ----------------------------------------
  // per-mode clock map
  // ----------------------------------------
  always_comb begin
    sleep_en = '0;
    mode_ok  = 1'b1;
    case (mode_sel)
      `SMDG_MODE_IDLE: begin
        sleep_en = '{asy: 1'b1, adc: 1'b1, io: 1'b1, cpu: 1'b0,
                     osc: 1'b1};
      end
      `SMDG_MODE_NOISE: begin
        sleep_en = '{asy: 1'b1, adc: 1'b1, io: 1'b0, cpu: 1'b0,
                     osc: 1'b1};
      end
      `SMDG_MODE_PDOWN: begin
        sleep_en = '0;
      end
      `SMDG_MODE_PSAVE: begin
        sleep_en = '{asy: 1'b1, adc: 1'b0, io: 1'b0, cpu: 1'b0,
                     osc: 1'b0};
      end
      `SMDG_MODE_STANDBY: begin
        sleep_en = '{asy: 1'b0, adc: 1'b0, io: 1'b0, cpu: 1'b0,
                     osc: 1'b1};
      end
      `SMDG_MODE_XSTANDBY: begin
        sleep_en = '{asy: 1'b1, adc: 1'b0, io: 1'b0, cpu: 1'b0,
                     osc: 1'b1};
      end
      default: begin
        // reserved codes are refused; sleep is not entered
        mode_ok = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // wake qualification
  // ----------------------------------------
  always_comb begin
    // power-down alone cannot see internal events; power-save still takes them
    if (r.mode == `SMDG_MODE_PDOWN) begin
      wake_ok = wake.ext_irq;
    end else begin
      wake_ok = wake.ext_irq | wake.int_irq;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    next_r = r;
    case (r.fsm)
      smdg_pkg::SMDG_ACTIVE: begin
        if (sleep_req) begin
          next_r.bad = ~mode_ok;
          if (mode_ok) begin
            next_r.mode = mode_sel;
            next_r.en   = sleep_en;
            next_r.fsm  = smdg_pkg::SMDG_SLEEP;
          end
        end
      end
      smdg_pkg::SMDG_SLEEP: begin
        if (wake_ok) begin
          next_r.en  = `SMDG_EN_ALL;
          next_r.fsm = smdg_pkg::SMDG_WAKE;
        end
      end
      smdg_pkg::SMDG_WAKE: begin
        // held until the request drops, so a held request does not re-enter at once
        if (!sleep_req) begin
          next_r.fsm = smdg_pkg::SMDG_ACTIVE;
        end
      end
      default: begin
        next_r.fsm = smdg_pkg::SMDG_ACTIVE;
        next_r.en  = `SMDG_EN_ALL;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r.fsm  <= smdg_pkg::SMDG_ACTIVE;
      r.mode <= `SMDG_MODE_IDLE;
      r.en   <= `SMDG_EN_ALL;
      r.bad  <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  assign clk_en   = r.en;
  assign sleeping = (r.fsm == smdg_pkg::SMDG_SLEEP);
  assign mode_bad = r.bad;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_idle_map;
    @(posedge clk) disable iff (!rst_n)
      (sleeping && r.mode == `SMDG_MODE_IDLE) |->
        (!clk_en.cpu && clk_en.io && clk_en.adc && clk_en.osc);
  endproperty
  a_idle_map: assert property (p_idle_map)
    else $error("idle clock map wrong");

  property p_pdown_map;
    @(posedge clk) disable iff (!rst_n)
      (sleeping && r.mode == `SMDG_MODE_PDOWN) |-> (clk_en == '0);
  endproperty
  a_pdown_map: assert property (p_pdown_map)
    else $error("power-down left a clock running");

  property p_pdown_wake;
    @(posedge clk) disable iff (!rst_n)
      (sleeping && r.mode == `SMDG_MODE_PDOWN && !ext_sync) |=> sleeping;
  endproperty
  a_pdown_wake: assert property (p_pdown_wake)
    else $error("power-down left without external event");

  property p_psave_map;
    @(posedge clk) disable iff (!rst_n)
      (sleeping && r.mode == `SMDG_MODE_PSAVE) |->
        (clk_en.asy && !clk_en.osc && !clk_en.cpu && !clk_en.io &&
         !clk_en.adc);
  endproperty
  a_psave_map: assert property (p_psave_map)
    else $error("power-save clock map wrong");

  property p_noise_map;
    @(posedge clk) disable iff (!rst_n)
      (sleeping && r.mode == `SMDG_MODE_NOISE) |->
        (clk_en.asy && clk_en.adc && !clk_en.io && !clk_en.cpu);
  endproperty
  a_noise_map: assert property (p_noise_map)
    else $error("noise reduction clock map wrong");

  property p_stby_map;
    @(posedge clk) disable iff (!rst_n)
      (sleeping && r.mode == `SMDG_MODE_STANDBY) |->
        (clk_en.osc && !clk_en.asy && !clk_en.io && !clk_en.adc &&
         !clk_en.cpu);
  endproperty
  a_stby_map: assert property (p_stby_map)
    else $error("standby clock map wrong");

  property p_xstby_map;
    @(posedge clk) disable iff (!rst_n)
      (sleeping && r.mode == `SMDG_MODE_XSTANDBY) |->
        (clk_en.osc && clk_en.asy && !clk_en.cpu);
  endproperty
  a_xstby_map: assert property (p_xstby_map)
    else $error("extended standby clock map wrong");

  property p_bad_mode;
    @(posedge clk) disable iff (!rst_n)
      (!sleeping && r.fsm == smdg_pkg::SMDG_ACTIVE && sleep_req && !mode_ok)
        |=> (!sleeping && mode_bad);
  endproperty
  a_bad_mode: assert property (p_bad_mode)
    else $error("reserved mode entered sleep");

  property p_wake_restore;
    @(posedge clk) disable iff (!rst_n)
      (sleeping && wake_ok) |=> (!sleeping && clk_en == `SMDG_EN_ALL);
  endproperty
  a_wake_restore: assert property (p_wake_restore)
    else $error("wake did not restore clocks");

endmodule // smdg_ctrl
`default_nettype wire

// ==== verification/smdg_testbench.sv ====
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic                      clk = 1'b0;
  logic                      rst_n = 1'b0;
  logic [2:0]                mode_sel = 3'h0;
  logic                      sleep_req = 1'b0;
  logic                      ext_irq_pin = 1'b0;
  logic                      int_irq = 1'b0;
  smdg_pkg::smdg_clk_en_type clk_en;
  logic                      sleeping;
  logic                      mode_bad;
  int                        err_total = 0;
  int                        n_checks = 0;

  always #25 clk = ~clk;

  smdg_ctrl smdg_ctrl_inst (
    .clk         (clk),
    .rst_n       (rst_n),
    .mode_sel    (mode_sel),
    .sleep_req   (sleep_req),
    .ext_irq_pin (ext_irq_pin),
    .int_irq     (int_irq),
    .clk_en      (clk_en),
    .sleeping    (sleeping),
    .mode_bad    (mode_bad)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [4:0] seen,
                     input logic [4:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict;
    if (err_total == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // one-cycle request; hold keeps sleep_req up past the take
  task automatic request(input logic [2:0] m, input logic hold);
    @(negedge clk);
    mode_sel = m;
    sleep_req = 1'b1;
    @(negedge clk);
    sleep_req = hold;
  endtask

  task automatic wake_by(input logic ext);
    int i;
    @(negedge clk);
    if (ext) begin
      ext_irq_pin = 1'b1;
    end else begin
      int_irq = 1'b1;
    end
    // bounded: sync path adds two cycles
    for (i = 0; i < 8 && sleeping !== 1'b0; i++) @(negedge clk);
    chk("sleeping", {4'h0, sleeping}, 5'h00);
    chk("clk_en", clk_en, 5'h1f);
    ext_irq_pin = 1'b0;
    int_irq = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  // one sleep entry; k masks bits the mode leaves open
  task automatic mode_case(input logic [2:0] m, input logic [4:0] e,
                           input logic [4:0] k);
    logic [4:0] v;
    request(m, 1'b0);
    v = clk_en & k;
    chk("sleeping", {4'h0, sleeping}, 5'h01);
    chk("clk_en", v, e);
    wake_by(1'b0);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_modes;
    mode_case(3'h0, 5'h1d, 5'h1f);
    // osc bit left open in noise reduction
    mode_case(3'h1, 5'h18, 5'h1e);
    mode_case(3'h3, 5'h10, 5'h1f);
    mode_case(3'h6, 5'h01, 5'h1f);
    mode_case(3'h7, 5'h11, 5'h1f);
  endtask

  task automatic t_pdown;
    request(3'h2, 1'b0);
    chk("clk_en", clk_en, 5'h00);
    @(negedge clk);
    int_irq = 1'b1;
    repeat (6) @(negedge clk);
    chk("sleeping", {4'h0, sleeping}, 5'h01);
    chk("clk_en", clk_en, 5'h00);
    int_irq = 1'b0;
    wake_by(1'b1);
  endtask

  task automatic t_reserved;
    for (int i = 4; i < 6; i++) begin
      request(3'(i), 1'b0);
      chk("mode_bad", {4'h0, mode_bad}, 5'h01);
      chk("sleeping", {4'h0, sleeping}, 5'h00);
      chk("clk_en", clk_en, 5'h1f);
    end
    request(3'h0, 1'b0);
    chk("mode_bad", {4'h0, mode_bad}, 5'h00);
    wake_by(1'b0);
  endtask

  // request left high across the wake must not re-enter
  task automatic t_rehold;
    request(3'h6, 1'b1);
    wake_by(1'b0);
    repeat (3) @(negedge clk);
    chk("sleeping", {4'h0, sleeping}, 5'h00);
    chk("clk_en", clk_en, 5'h1f);
    sleep_req = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic t_reset;
    request(3'h2, 1'b0);
    rst_n = 1'b0;
    @(negedge clk);
    chk("clk_en", clk_en, 5'h1f);
    chk("sleeping", {4'h0, sleeping}, 5'h00);
    chk("mode_bad", {4'h0, mode_bad}, 5'h00);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk("clk_en", clk_en, 5'h1f);
    chk("sleeping", {4'h0, sleeping}, 5'h00);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(negedge clk);
    chk("clk_en", clk_en, 5'h1f);
    chk("mode_bad", {4'h0, mode_bad}, 5'h00);
    rst_n = 1'b1;
    t_modes();
    t_pdown();
    t_reserved();
    t_rehold();
    t_reset();
    print_verdict();
  end

  // whole run needs under a hundred cycles
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
